// file: tb/srg_fet_model.sv
// Sense comparators seen across the rectifier switch, in microvolts
`default_nettype none

module srg_fet_model #(
    parameter int TON_UV  = -100000,
    parameter int TOFF_UV = -500,
    parameter int RST_UV  = 200000
) (
    input  wire logic signed [31:0] senseUv,
    output logic                    belowOn,
    output logic                    aboveOff,
    output logic                    aboveReset
);
    timeunit 1ns;
    timeprecision 100ps;

    assign belowOn    = senseUv < TON_UV;
    assign aboveOff   = senseUv > TOFF_UV;
    assign aboveReset = senseUv > RST_UV;
endmodule

`default_nettype wire

// file: tb/srg_top_asserts.sv
// Port checker for the rectifier gate drive sequencer
`default_nettype none

module srg_top_asserts (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic belowTurnOnThreshold,
    input wire logic aboveTurnOffThreshold,
    input wire logic lightLoadDetectPin,
    input wire logic gateDriveOutput,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import srg_pkg::*;

    logic [7:0] onCnt_reg, onCnt_next, lowCnt_reg, lowCnt_next;
    logic [3:0] lldHist_reg, lldHist_next;
    logic       quiet;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // Run lengths of drive high and low, light-load history
    always_comb begin
        onCnt_next   = gateDriveOutput ?
                       onCnt_reg + {7'h00, onCnt_reg != 8'hFF} : 8'h00;
        lowCnt_next  = (gateDriveOutput || lightLoadDetectPin) ?
                       8'h00 : lowCnt_reg + {7'h00, lowCnt_reg != 8'hFF};
        lldHist_next = {lldHist_reg[2:0], lightLoadDetectPin};
    end

    // Helper registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            onCnt_reg   <= 8'h00;
            lowCnt_reg  <= 8'h00;
            lldHist_reg <= 4'h0;
        end else begin
            onCnt_reg   <= onCnt_next;
            lowCnt_reg  <= lowCnt_next;
            lldHist_reg <= lldHist_next;
        end
    end

    // No light-load activity in the last four cycles
    assign quiet = lldHist_reg == 4'h0;

    rst_low_a: assert property ($past(reset) |-> !gateDriveOutput)
        else $error("drive high after reset");
    lld_low_a: assert property (lldHist_reg == 4'hF
        |-> !gateDriveOutput) else $error("drive high while disabled");
    min_on_a: assert property ($fell(gateDriveOutput) && quiet
        |-> onCnt_reg >= 8'h0F) else $error("on blanking too short");
    min_off_a: assert property ($rose(gateDriveOutput)
        |-> lowCnt_reg >= 8'h3E) else $error("off blanking too short");
    on_cause_a: assert property ($rose(gateDriveOutput)
        |-> $past(belowTurnOnThreshold, 3)) else $error("turn-on uncaused");
    off_cause_a: assert property ($fell(gateDriveOutput) && quiet
        |-> $past(aboveTurnOffThreshold, 3)) else $error("turn-off uncaused");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid ##1 s_axi_awready && s_axi_wready)
        else $error("write channel not freed");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready) else $error("read not freed");

    cover property ($rose(gateDriveOutput));
    cover property (lldHist_reg == 4'hF);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind srg_top srg_top_asserts srg_top_asserts_i (
    .ref_clk, .reset, .belowTurnOnThreshold, .aboveTurnOffThreshold,
    .lightLoadDetectPin, .gateDriveOutput, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready
);

`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the rectifier gate drive sequencer
`default_nettype none
`include "srg_defs.svh"

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
    num_errors++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import srg_pkg::*;

    localparam int HI = 1000000;
    localparam int MID = 0;
    localparam int LO = -300000;
    localparam int CND = -1000;
    localparam int TRIP = -400;
    localparam logic [1:0] OK = `SRG_RESP_OKAY;
    localparam logic [1:0] ER = `SRG_RESP_SLVERR;

    typedef struct {
        logic       wr;
        srg_addr_t  addr;
        srg_word_t  data;
        logic [1:0] resp;
        srg_word_t  rd;
    } srg_row_s;

    // Register accesses and the answers they should give
    srg_row_s rows [10] = '{
        '{1'h0, 8'h00, 32'h0, OK, 32'h0}, '{1'h0, 8'h04, 32'h0, OK, 32'h0},
        '{1'h1, 8'h00, 32'hFFFF0014, OK, 32'h0},
        '{1'h0, 8'h00, 32'h0, OK, 32'h14}, '{1'h1, 8'h04, 32'h50, OK, 32'h0},
        '{1'h0, 8'h04, 32'h0, OK, 32'h50}, '{1'h1, 8'h08, 32'hFF, OK, 32'h0},
        '{1'h1, 8'h0C, 32'h1, ER, 32'h0}, '{1'h0, 8'h0C, 32'h0, ER, 32'h0},
        '{1'h0, 8'h02, 32'h0, ER, 32'h0}};

    logic               ref_clk = 1'h0;
    logic               reset = 1'h1;
    logic               lightLoadDetectPin = 1'h0;
    logic signed [31:0] senseUv = HI;
    logic               belowTurnOnThreshold, aboveTurnOffThreshold;
    logic               aboveBlankRestartThreshold, gateDriveOutput;
    srg_addr_t          s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    srg_word_t          s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]         s_axi_wstrb = 4'hF;
    logic               s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic               s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic               s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic               s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]         s_axi_bresp, s_axi_rresp, r;
    int                 c, num_errors = 0, cmp_count = 0;

    always #2 ref_clk = ~ref_clk;

    srg_top srg_top_i (
        .ref_clk, .reset, .belowTurnOnThreshold, .aboveTurnOffThreshold,
        .aboveBlankRestartThreshold, .lightLoadDetectPin, .gateDriveOutput,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready
    );

    srg_fet_model srg_fet_model_i (
        .senseUv,
        .belowOn    (belowTurnOnThreshold),
        .aboveOff   (aboveTurnOffThreshold),
        .aboveReset (aboveBlankRestartThreshold)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic setSense(input int v);
        @(posedge ref_clk);
        senseUv <= v;
    endtask

    // Write one word, wait for the response
    task automatic axiWrite(input srg_addr_t a, input srg_word_t v,
                            output logic [1:0] rs);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        rs = 2'h3;
        while (rs === 2'h3) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) rs = s_axi_bresp;
        end
        s_axi_bready <= 1'h0;
    endtask

    // Read one word, wait for the data
    task automatic axiRead(input srg_addr_t a, output srg_word_t v,
                           output logic [1:0] rs);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        rs = 2'h3;
        while (rs === 2'h3) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
                rs = s_axi_rresp;
                v = s_axi_rdata;
            end
        end
        s_axi_rready <= 1'h0;
    endtask

    // Hold sense high n cycles, then ask for turn-on
    task automatic fire(input int n, input logic clr, input logic exp);
        logic rose;
        if (clr) begin
            setSense(MID);
            tick(4);
        end
        setSense(HI);
        tick(n);
        setSense(LO);
        rose = 1'h0;
        for (int i = 0; i < 8 && !rose; i++) begin
            @(posedge ref_clk);
            if (gateDriveOutput === 1'h1) rose = 1'h1;
        end
        `CHK(rose, exp)
    endtask

    // Cycles until drive drops once sense moves to v
    task automatic onLen(input int v, output int n);
        setSense(v);
        n = 0;
        while (gateDriveOutput === 1'h1 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog, well beyond the roughly 1100 cycles the run needs
    initial begin
        tick(30000);
        num_errors++;
        end_sim;
    end

    initial begin
        tick(5);
        reset <= 1'h0;
        fire(40, 1'h0, 1'h0);
        fire(70, 1'h0, 1'h1);
        @(posedge ref_clk);
        reset <= 1'h1;
        tick(5);
        `CHK(gateDriveOutput, 1'h0)
        reset <= 1'h0;
        fire(66, 1'h0, 1'h1);
        onLen(HI, c);
        `CHK(c inside {[13:19]}, 1'h1)
        fire(58, 1'h1, 1'h0);
        fire(70, 1'h1, 1'h1);
        setSense(CND);
        tick(40);
        `CHK(gateDriveOutput, 1'h1)
        onLen(TRIP, c);
        `CHK(c inside {[1:4]}, 1'h1)
        foreach (rows[i]) begin
            if (rows[i].wr) axiWrite(rows[i].addr, rows[i].data, r);
            else axiRead(rows[i].addr, d, r);
            `CHK(r, rows[i].resp)
            if (!rows[i].wr) `CHK(d, rows[i].rd)
        end
        s_axi_wstrb <= 4'h1;
        axiWrite(8'h00, 32'hFF14, r);
        axiRead(8'h00, d, r);
        `CHK(d, 32'h14)
        fire(74, 1'h1, 1'h0);
        setSense(MID);
        tick(4);
        setSense(HI);
        tick(50);
        setSense(MID);
        tick(3);
        fire(50, 1'h0, 1'h0);
        fire(90, 1'h0, 1'h1);
        onLen(HI, c);
        `CHK(c inside {[19:25]}, 1'h1)
        fire(90, 1'h1, 1'h1);
        @(posedge ref_clk);
        lightLoadDetectPin <= 1'h1;
        tick(6);
        `CHK(gateDriveOutput, 1'h0)
        fire(90, 1'h1, 1'h0);
        axiRead(8'h08, d, r);
        `CHK(d[4:0], 5'h18)
        setSense(HI);
        lightLoadDetectPin <= 1'h0;
        fire(84, 1'h0, 1'h1);
        end_sim;
    end
endmodule

`default_nettype wire

// file: verilog/srg_blank_timer.sv
// Blanking timer: counts while run is high, clears when run drops
`default_nettype none

module srg_blank_timer (
    input  wire logic ref_clk,
    input  wire logic reset,
    srg_timer_if.tmr  tif
);
    import srg_pkg::*;

    srg_cfg_t count_reg;
    srg_cfg_t count_next;

    // ------------------------------------------------------------
    // Count control
    // ------------------------------------------------------------
    always_comb begin
        count_next = count_reg;
        if (!tif.run) begin
            count_next = '0;                       // Restart on drop
        end else if (count_reg < tif.limit) begin
            count_next = count_reg + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // Expiry only counts while still running
    assign tif.done = tif.run && (count_reg >= tif.limit);
    assign tif.busy = tif.run && (count_reg < tif.limit);
endmodule

`default_nettype wire

// file: verilog/srg_defs.svh
// Constants for the rectifier gate drive sequencer
`ifndef SRG_DEFS_SVH
`define SRG_DEFS_SVH

// ------------------------------------------------------------
// Clock and blanking floors
// ------------------------------------------------------------
`define SRG_CLK_PERIOD_NS   4
`define SRG_MIN_TON_NS      55
`define SRG_MIN_TOFF_NS     245
// Least times round up to whole cycles
`define SRG_TON_FLOOR_CYC   ((`SRG_MIN_TON_NS + `SRG_CLK_PERIOD_NS - 1) / `SRG_CLK_PERIOD_NS)
`define SRG_TOFF_FLOOR_CYC  ((`SRG_MIN_TOFF_NS + `SRG_CLK_PERIOD_NS - 1) / `SRG_CLK_PERIOD_NS)

// ------------------------------------------------------------
// Register map (word indices in address bits 3:2) and fields
// ------------------------------------------------------------
`define SRG_ADDR_W          8
`define SRG_CFG_W           16
`define SRG_IDX_TON_CFG     2'h0
`define SRG_IDX_TOFF_CFG    2'h1
`define SRG_IDX_STATUS      2'h2
`define SRG_TON_CFG_RST     16'h0000
`define SRG_TOFF_CFG_RST    16'h0000
`define SRG_STAT_DRIVE      0
`define SRG_STAT_STATE_LO   1
`define SRG_STAT_STATE_HI   3
`define SRG_STAT_DISABLED   4
`define SRG_STAT_ON_RUN     5
`define SRG_STAT_OFF_RUN    6
`define SRG_RESP_OKAY       2'h0
`define SRG_RESP_SLVERR     2'h2

`endif

// file: verilog/srg_pkg.sv
// Types for the rectifier gate drive sequencer
`default_nettype none

package srg_pkg;
    typedef logic [15:0] srg_cfg_t;
    typedef logic [7:0]  srg_addr_t;
    typedef logic [31:0] srg_word_t;
    typedef enum logic [2:0] {
        ST_WAIT_OFF = 3'b000,
        ST_ARMED    = 3'b001,
        ST_ON_BLANK = 3'b010,
        ST_ON       = 3'b011,
        ST_DISABLED = 3'b100
    } srg_state_e;
endpackage

`default_nettype wire

// file: verilog/srg_sync.sv
// Two-stage synchroniser for asynchronous comparator and pin levels
`default_nettype none

module srg_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_next;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    always_comb begin
        meta_next = asyncIn;
        sync_next = meta_reg;
    end

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_reg <= '0;
            syncOut  <= '0;
        end else begin
            meta_reg <= meta_next;
            syncOut  <= sync_next;
        end
    end
endmodule

`default_nettype wire

// file: verilog/srg_timer_if.sv
// Link between the sequencer and one blanking timer
`default_nettype none

interface srg_timer_if;
    logic             run;
    srg_pkg::srg_cfg_t limit;
    logic             done;
    logic             busy;
    modport ctrl (output run, output limit, input done, input busy);
    modport tmr  (input run, input limit, output done, output busy);
endinterface

`default_nettype wire

// file: verilog/srg_top.sv
// Gate drive sequencer of a synchronous rectifier with AXI4-Lite registers
//
// Behaviour
// - Raise gate drive when below turn-on threshold and no blanking forbids.
// - Each turn-on starts min on-time blanking; turn-off comparator ignored.
// - Min on-time length comes from a configuration setting, not a constant.
// - After min on-time, drop gate drive at once above turn-off threshold.
// - Min off-time timer starts when sense rises above restart threshold.
// - Min off-time length has its own independent configuration setting.
// - While off-time runs, falling below restart threshold resets the timer.
// - After such reset, timer restarts when sense climbs back above.
// - No new drive until one full off-time elapses without reset.
// - After power-up or wake-up, driver waits one uninterrupted off-time.
// - At start-up or wake-up, timer starts at once if sense is above.
// - Leaving light-load disable mode counts as a wake-up event.
// - Min on-time floors at 55 ns, min off-time at 245 ns.
// - In light-load disable mode gate drive stays low regardless.
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`default_nettype none
`include "srg_defs.svh"

module srg_top (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // Comparator results and light-load pin (asynchronous)
    input  wire logic              belowTurnOnThreshold,
    input  wire logic              aboveTurnOffThreshold,
    input  wire logic              aboveBlankRestartThreshold,
    input  wire logic              lightLoadDetectPin,
    output logic                   gateDriveOutput,
    // AXI4-Lite slave
    input  wire srg_pkg::srg_addr_t s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire srg_pkg::srg_word_t s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire srg_pkg::srg_addr_t s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output srg_pkg::srg_word_t     s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    import srg_pkg::*;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Apply the configured length but never below the floor
    function automatic srg_cfg_t clampLimit(input srg_cfg_t cfg,
                                            input srg_cfg_t floorCyc);
        clampLimit = (cfg < floorCyc) ? floorCyc : cfg;
    endfunction

    // Merge the low two byte lanes into a setting
    function automatic srg_cfg_t mergeLanes(input srg_cfg_t old,
                                            input srg_word_t data,
                                            input logic [3:0] strb);
        srg_cfg_t res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        mergeLanes = res;
    endfunction

    // Whether an address hits one of the three registers (0x00, 0x04, 0x08)
    function automatic logic mapped(input srg_addr_t addr);
        mapped = (addr[7:4] == 4'h0) && (addr[1:0] == 2'h0)
                 && (addr[3:2] <= `SRG_IDX_STATUS);
    endfunction

    localparam srg_cfg_t TonFloor  = 16'(`SRG_TON_FLOOR_CYC);
    localparam srg_cfg_t ToffFloor = 16'(`SRG_TOFF_FLOOR_CYC);

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [3:0] pinSync;
    logic       csBelowOn;
    logic       csAboveOff;
    logic       csAboveRestart;
    logic       lightLoadOff;

    srg_sync #(.WIDTH(4)) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .asyncIn ({lightLoadDetectPin, aboveBlankRestartThreshold,
                   aboveTurnOffThreshold, belowTurnOnThreshold}),
        .syncOut (pinSync)
    );

    assign csBelowOn      = pinSync[0];
    assign csAboveOff     = pinSync[1];
    assign csAboveRestart = pinSync[2];
    assign lightLoadOff   = pinSync[3];

    // ------------------------------------------------------------
    // Blanking timers
    // ------------------------------------------------------------
    srg_timer_if onTif ();
    srg_timer_if offTif ();

    srg_blank_timer u_on_timer (
        .ref_clk (ref_clk),
        .reset   (reset),
        .tif     (onTif)
    );

    srg_blank_timer u_off_timer (
        .ref_clk (ref_clk),
        .reset   (reset),
        .tif     (offTif)
    );

    srg_cfg_t   tonCfg_reg;
    srg_cfg_t   tonCfg_next;
    srg_cfg_t   toffCfg_reg;
    srg_cfg_t   toffCfg_next;
    srg_state_e state_reg;
    srg_state_e state_next;
    logic       drive_reg;
    logic       drive_next;

    assign onTif.limit  = clampLimit(tonCfg_reg, TonFloor);
    assign offTif.limit = clampLimit(toffCfg_reg, ToffFloor);

    assign onTif.run = (state_reg == ST_ON_BLANK);

    // off timer counts above restart, clears below
    assign offTif.run = (state_reg == ST_WAIT_OFF) && csAboveRestart;

    // ------------------------------------------------------------
    // Drive sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_WAIT_OFF: begin
                if (offTif.done) begin
                    state_next = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (csBelowOn) begin
                    state_next = ST_ON_BLANK;
                end
            end
            ST_ON_BLANK: begin
                if (onTif.done) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (csAboveOff) begin
                    state_next = ST_WAIT_OFF;
                end
            end
            ST_DISABLED: begin
                if (!lightLoadOff) begin
                    state_next = ST_WAIT_OFF;
                end
            end
            default: begin
                state_next = ST_WAIT_OFF;
            end
        endcase
        if (lightLoadOff) begin
            state_next = ST_DISABLED;
        end
        drive_next = (state_next == ST_ON_BLANK) || (state_next == ST_ON);
    end

    // reset to off-time wait, drive low
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_WAIT_OFF;
            drive_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            drive_reg <= drive_next;
        end
    end

    assign gateDriveOutput = drive_reg;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic      awHeld_reg;
    logic      awHeld_next;
    srg_addr_t awAddr_reg;
    srg_addr_t awAddr_next;
    logic      wHeld_reg;
    logic      wHeld_next;
    srg_word_t wData_reg;
    srg_word_t wData_next;
    logic [3:0] wStrb_reg;
    logic [3:0] wStrb_next;
    logic      awReady_next;
    logic      wReady_next;
    logic      bValid_next;
    logic [1:0] bResp_next;

    // Capture address and data in either order, answer after both
    always_comb begin
        awHeld_next  = awHeld_reg;
        awAddr_next  = awAddr_reg;
        wHeld_next   = wHeld_reg;
        wData_next   = wData_reg;
        wStrb_next   = wStrb_reg;
        bValid_next  = s_axi_bvalid;
        bResp_next   = s_axi_bresp;
        tonCfg_next  = tonCfg_reg;
        toffCfg_next = toffCfg_reg;
        if (s_axi_bvalid && s_axi_bready) begin
            bValid_next = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_next = 1'b1;
            awAddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_next = 1'b1;
            wData_next = s_axi_wdata;
            wStrb_next = s_axi_wstrb;
        end
        if (awHeld_next && wHeld_next && !s_axi_bvalid) begin
            awHeld_next = 1'b0;
            wHeld_next  = 1'b0;
            bValid_next = 1'b1;
            bResp_next  = mapped(awAddr_next) ? `SRG_RESP_OKAY
                                              : `SRG_RESP_SLVERR;
            if (mapped(awAddr_next)) begin
                if (awAddr_next[3:2] == `SRG_IDX_TON_CFG) begin
                    tonCfg_next = mergeLanes(tonCfg_reg, wData_next,
                                             wStrb_next);
                end
                if (awAddr_next[3:2] == `SRG_IDX_TOFF_CFG) begin
                    toffCfg_next = mergeLanes(toffCfg_reg, wData_next,
                                              wStrb_next);
                end
            end
        end
        awReady_next = !awHeld_next && !bValid_next;
        wReady_next  = !wHeld_next && !bValid_next;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            awHeld_reg    <= 1'b0;
            awAddr_reg    <= '0;
            wHeld_reg     <= 1'b0;
            wData_reg     <= '0;
            wStrb_reg     <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SRG_RESP_OKAY;
            tonCfg_reg    <= `SRG_TON_CFG_RST;
            toffCfg_reg   <= `SRG_TOFF_CFG_RST;
        end else begin
            awHeld_reg    <= awHeld_next;
            awAddr_reg    <= awAddr_next;
            wHeld_reg     <= wHeld_next;
            wData_reg     <= wData_next;
            wStrb_reg     <= wStrb_next;
            s_axi_awready <= awReady_next;
            s_axi_wready  <= wReady_next;
            s_axi_bvalid  <= bValid_next;
            s_axi_bresp   <= bResp_next;
            tonCfg_reg    <= tonCfg_next;
            toffCfg_reg   <= toffCfg_next;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    srg_word_t  statusWord;
    srg_word_t  readWord;
    logic       arReady_next;
    logic       rValid_next;
    srg_word_t  rData_next;
    logic [1:0] rResp_next;

    // Live sequencer state
    always_comb begin
        statusWord = '0;
        statusWord[`SRG_STAT_DRIVE] = drive_reg;
        statusWord[`SRG_STAT_STATE_HI:`SRG_STAT_STATE_LO] = state_reg;
        statusWord[`SRG_STAT_DISABLED] = (state_reg == ST_DISABLED);
        statusWord[`SRG_STAT_ON_RUN]   = onTif.busy;
        statusWord[`SRG_STAT_OFF_RUN]  = offTif.busy;
    end

    // Read mux, unmapped reads zero
    always_comb begin
        readWord = '0;
        if (mapped(s_axi_araddr)) begin
            case (s_axi_araddr[3:2])
                `SRG_IDX_TON_CFG:  readWord = {16'h0000, tonCfg_reg};
                `SRG_IDX_TOFF_CFG: readWord = {16'h0000, toffCfg_reg};
                `SRG_IDX_STATUS:   readWord = statusWord;
                default:           readWord = '0;
            endcase
        end
    end

    // One read at a time, answered one cycle after the address
    always_comb begin
        arReady_next = s_axi_arready;
        rValid_next  = s_axi_rvalid;
        rData_next   = s_axi_rdata;
        rResp_next   = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            rValid_next  = 1'b0;
            arReady_next = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            arReady_next = 1'b0;
            rValid_next  = 1'b1;
            rData_next   = readWord;
            rResp_next   = mapped(s_axi_araddr) ? `SRG_RESP_OKAY
                                                : `SRG_RESP_SLVERR;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `SRG_RESP_OKAY;
        end else begin
            s_axi_arready <= arReady_next;
            s_axi_rvalid  <= rValid_next;
            s_axi_rdata   <= rData_next;
            s_axi_rresp   <= rResp_next;
        end
    end
endmodule

`default_nettype wire
